// *** rtl/bcc_charger.sv ***
// Charger control device: source selection, charge phases, timers, fault
`timescale 1ns/1ps
`default_nettype none
module bcc_charger (
    // Clock, reset, enable
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // Host link
    bcc_link_if.device link,
    // Analog comparator indications (asynchronous)
    input wire logic ac_valid_i,
    input wire logic usb_valid_i,
    input wire logic ac_ovp_i,
    input wire logic batt_low_i,
    input wire logic batt_rch_i,
    input wire logic therm_cold_i,
    input wire logic therm_hot_i,
    input wire logic i_below_term_i,
    input wire logic i_below_taper_i,
    input wire logic batt_replaced_i,
    // Power stage commands
    output logic pass_on_o,
    output logic [3:0] current_o,
    output logic detect_cur_o,
    output logic usb_500_o,
    output bcc_pkg::bcc_src_t src_o,
    output logic sleep_o
);
    import bcc_pkg::*;

    localparam int NSYNC = 10;

    typedef struct packed {
        logic [NSYNC-1:0] s1;
        logic [NSYNC-1:0] s2;
        bcc_phase_t phase;
        bcc_src_t src;
        logic [TMR_W-1:0] usb_tmr;
        logic [TMR_W-1:0] pre_tmr;
        logic [TMR_W-1:0] fast_tmr;
        logic [TMR_W-1:0] taper_tmr;
        logic fault;
        logic booted;
        logic pass_on;
        logic [3:0] current;
        logic detect;
        logic usb500;
        logic sleep;
        logic [ST_W-1:0] status;
    } bcc_dev_t;

    bcc_dev_t q, d;

    function automatic logic tmr_hit(input logic [TMR_W-1:0] t, input int unsigned lim);
        tmr_hit = t >= TMR_W'(lim - 1);
    endfunction

    logic ac_v, usb_v, ovp, blow, brch, cold, hot, iterm, itaper, brepl;
    assign {ac_v, usb_v, ovp, blow, brch, cold, hot, iterm, itaper, brepl} = q.s2;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic ac_ok, usb_ok, usb_ready, therm_bad, tmr_en, running;
        d = q;
        d.s1 = {ac_valid_i, usb_valid_i, ac_ovp_i, batt_low_i, batt_rch_i,
                therm_cold_i, therm_hot_i, i_below_term_i, i_below_taper_i,
                batt_replaced_i};
        d.s2 = q.s1;
        ac_ok = ac_v && !ovp;
        usb_ok = usb_v && !link.config_bits[CFG_USB_DIS];
        therm_bad = cold || hot;
        tmr_en = link.config_bits[CFG_TMR_EN];
        // USB start delay; host may veto during it
        if (!usb_ok || ac_ok) begin
            d.usb_tmr = '0;
        end else if (!tmr_hit(q.usb_tmr, USB_DELAY_CYC)) begin
            d.usb_tmr = q.usb_tmr + TMR_W'(1);
        end
        usb_ready = usb_ok && tmr_hit(q.usb_tmr, USB_DELAY_CYC);
        if (ac_ok) begin
            d.src = BCC_SRC_AC;
        end else if (usb_ready) begin
            d.src = BCC_SRC_USB;
        end else begin
            d.src = BCC_SRC_NONE;
        end
        d.usb500 = link.config_bits[CFG_USB500];
        // Fault clear: host, replacement
        if (link.clear_fault || brepl) begin
            d.fault = 1'b0;
        end
        running = d.src != BCC_SRC_NONE && !link.config_bits[CFG_CHG_DIS];
        d.sleep = !(ac_v || usb_v);
        if (!running) begin
            d.phase = d.sleep ? BCC_SLEEP : BCC_WAIT;
            d.pre_tmr = '0;
            d.fast_tmr = '0;
            d.taper_tmr = '0;
        end else if (therm_bad) begin
            // Timers hold their value while suspended
            d.phase = q.phase;
        end else begin
            unique case (q.phase)
                BCC_SLEEP, BCC_WAIT: begin
                    // Battery low sampled at start of charging
                    d.phase = d.fault ? BCC_FAULT : (blow ? BCC_PRECOND : BCC_CC);
                    d.pre_tmr = '0;
                end
                BCC_PRECOND: begin
                    if (!blow) begin
                        d.phase = BCC_CC;
                    end else if (tmr_hit(q.pre_tmr, PRECHG_CYC)) begin
                        d.phase = BCC_FAULT;
                        d.fault = 1'b1;
                    end else begin
                        d.pre_tmr = q.pre_tmr + TMR_W'(1);
                    end
                end
                BCC_CC, BCC_CV: begin
                    if (q.phase == BCC_CC && itaper) begin
                        d.phase = BCC_CV;
                    end
                    if (iterm) begin
                        d.phase = BCC_DONE;
                    end else if (tmr_en && tmr_hit(q.fast_tmr, FAST_CYC)) begin
                        d.phase = BCC_FAULT;
                        d.fault = 1'b1;
                    end else if (tmr_en) begin
                        d.fast_tmr = q.fast_tmr + TMR_W'(1);
                    end
                    if (q.phase == BCC_CV && tmr_en && itaper) begin
                        if (tmr_hit(q.taper_tmr, TAPER_CYC)) begin
                            d.phase = BCC_DONE;
                        end else begin
                            d.taper_tmr = q.taper_tmr + TMR_W'(1);
                        end
                    end else if (q.phase == BCC_CV) begin
                        d.taper_tmr = '0;
                    end
                end
                BCC_DONE: begin
                    d.fast_tmr = '0;
                    d.taper_tmr = '0;
                    if (brch) begin
                        d.phase = BCC_CC;
                    end
                end
                BCC_FAULT: begin
                    if (!d.fault) begin
                        d.phase = BCC_WAIT;
                    end
                end
                default: d.phase = BCC_WAIT;
            endcase
        end
        // Output commands follow the registered phase
        d.detect = d.phase == BCC_FAULT;
        d.pass_on = !therm_bad && (d.phase == BCC_PRECOND || d.phase == BCC_CC
                    || d.phase == BCC_CV || d.detect);
        if (!d.pass_on || d.detect) begin
            d.current = CUR_OFF;
        end else if (d.phase == BCC_PRECOND) begin
            d.current = CUR_TENTH;
        end else begin
            d.current = CUR_FULL;
        end
        d.status = '0;
        d.status[ST_PHASE_LO +: 3] = d.phase;
        d.status[ST_SRC_LO +: 2] = d.src;
        d.status[ST_FAULT] = d.fault;
        d.status[ST_THERM] = therm_bad;
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '0;
        end else if (ce_i) begin
            q <= d;
        end
    end

    assign pass_on_o = q.pass_on;
    assign current_o = q.current;
    assign detect_cur_o = q.detect;
    assign usb_500_o = q.usb500;
    assign src_o = q.src;
    assign sleep_o = q.sleep;
    assign link.status_bits = q.status;
endmodule
`default_nettype wire

// *** rtl/bcc_pkg.sv ***
// Package with constants, encodings and register layout for the charger control pair
//
// Notes on behaviour
// - Both inputs valid: adapter is the source
// - Adapter absent, USB valid: USB is source
// - USB defaults 100 mA; host may pick 500
// - Host disables charger, or only USB charging
// - USB charging starts after delay; host may veto
// - Adapter overvoltage inhibits adapter charging
// - Charging starts alone above undervoltage lockout
// - Out-of-range temperature: switch off, freeze timers
// - Normal temperature resumes with frozen timer values
// - Phases: conditioning, constant current, constant voltage
// - Battery low at power-up enters preconditioning
// - Preconditioning current is one tenth setting
// - Precharge timer expiry: charger off, fault set
// - During fault apply only detection current
// - Fault cleared by reset, replacement, host clear
// - Low current ends charge; timer is backup
// - Terminated charge restarts below recharge threshold
// - No input present puts charger to sleep
// - Taper timer ends charge; host enables fast and taper timers
package bcc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Timing at 100 MHz
    localparam int unsigned CLK_MHZ = 100;
    // Our own choices, kept short so a full timeout fits a short run
    localparam int unsigned USB_DELAY_US = 50;
    localparam int unsigned PRECHG_TIME_US = 100;
    localparam int unsigned FAST_TIME_US = 300;
    localparam int unsigned TAPER_TIME_US = 100;
    localparam int unsigned USB_DELAY_CYC = USB_DELAY_US * CLK_MHZ;
    localparam int unsigned PRECHG_CYC = PRECHG_TIME_US * CLK_MHZ;
    localparam int unsigned FAST_CYC = FAST_TIME_US * CLK_MHZ;
    localparam int unsigned TAPER_CYC = TAPER_TIME_US * CLK_MHZ;
    localparam int unsigned TMR_W = 24;

    ////////////////////////////////////////////////////////////////////////////
    // Current command codes, in tenths of the programmed setting
    localparam logic [3:0] CUR_OFF = 4'h0;
    localparam logic [3:0] CUR_DETECT = 4'h1;
    localparam logic [3:0] CUR_TENTH = 4'h1;
    localparam logic [3:0] CUR_FULL = 4'ha;
    // Detection current flagged separately from the tenth step
    localparam logic SRC_NONE = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // Source selection
    typedef enum logic [1:0] {
        BCC_SRC_NONE = 2'h0,
        BCC_SRC_AC = 2'h1,
        BCC_SRC_USB = 2'h2
    } bcc_src_t;

    // Charge phases, Gray coded along the usual path
    typedef enum logic [2:0] {
        BCC_SLEEP = 3'h0,
        BCC_PRECOND = 3'h1,
        BCC_CC = 3'h3,
        BCC_CV = 3'h2,
        BCC_DONE = 3'h6,
        BCC_FAULT = 3'h7,
        BCC_WAIT = 3'h4
    } bcc_phase_t;

    ////////////////////////////////////////////////////////////////////////////
    // Host register map (APB, byte addresses)
    localparam logic [7:0] ADDR_CONFIG = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_CMD = 8'h08;

    // charger_config_reg fields
    localparam int unsigned CFG_USB500 = 0;
    localparam int unsigned CFG_USB_DIS = 1;
    localparam int unsigned CFG_TMR_EN = 5;
    localparam int unsigned CFG_CHG_DIS = 6;
    localparam int unsigned CFG_W = 7;
    localparam logic [CFG_W-1:0] CFG_RESET = 7'h00;

    // charger_status_reg fields
    localparam int unsigned ST_PHASE_LO = 0;
    localparam int unsigned ST_SRC_LO = 3;
    localparam int unsigned ST_FAULT = 5;
    localparam int unsigned ST_THERM = 6;
    localparam int unsigned ST_W = 7;

    // Command register bit: writing one clears the fault
    localparam int unsigned CMD_CLR_FAULT = 0;

endpackage

// *** rtl/bcc_link_if.sv ***
// Interface joining the charger control device and its host-side controller
`timescale 1ns/1ps
`default_nettype none
interface bcc_link_if;
    import bcc_pkg::*;
    logic [CFG_W-1:0] config_bits;
    logic clear_fault;
    logic [ST_W-1:0] status_bits;

    modport device (
        input config_bits,
        input clear_fault,
        output status_bits
    );
    modport host (
        output config_bits,
        output clear_fault,
        input status_bits
    );
endinterface
`default_nettype wire

// *** rtl/bcc_host.sv ***
// Host-side controller: APB registers driving charger configuration and status
`timescale 1ns/1ps
`default_nettype none
module bcc_host (
    // Clock, reset, enable
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Link
    bcc_link_if.host link
);
    import bcc_pkg::*;

    typedef struct packed {
        logic [CFG_W-1:0] cfg;
        logic clr;
        logic [31:0] rdata;
        logic ready;
        logic err;
    } bcc_host_t;

    bcc_host_t q, d;

    always_comb begin
        logic access;
        d = q;
        d.clr = 1'b0;
        d.ready = 1'b0;
        d.err = 1'b0;
        access = psel_i && penable_i && !q.ready;
        // One wait state: answer registered on the edge after access starts
        if (access) begin
            d.ready = 1'b1;
            d.rdata = '0;
            unique case (paddr_i)
                ADDR_CONFIG: begin
                    if (pwrite_i) begin
                        d.cfg = pwdata_i[CFG_W-1:0];
                    end
                    d.rdata[CFG_W-1:0] = pwrite_i ? pwdata_i[CFG_W-1:0] : q.cfg;
                end
                ADDR_STATUS: d.rdata[ST_W-1:0] = link.status_bits;
                ADDR_CMD: begin
                    if (pwrite_i) begin
                        d.clr = pwdata_i[CMD_CLR_FAULT];
                    end
                end
                default: d.err = 1'b1;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '0;
        end else if (ce_i) begin
            q <= d;
        end
    end

    assign prdata_o = q.rdata;
    assign pready_o = q.ready;
    assign pslverr_o = q.err;
    assign link.config_bits = q.cfg;
    assign link.clear_fault = q.clr;
endmodule
`default_nettype wire

// *** testbench/bcc_link_asserts.sv ***
// Assertions on the link between the charger control device and its host controller
`timescale 1ns/1ps
`default_nettype none
module bcc_link_asserts
    import bcc_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Link signals
    input wire logic [CFG_W-1:0] config_bits,
    input wire logic clear_fault,
    input wire logic [ST_W-1:0] status_bits
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    logic [2:0] ph;
    assign ph = status_bits[2:0];
    ////////////////////////////////////////////////////////////////////////////
    property p_clr_pulse; clear_fault |=> !clear_fault; endproperty
    a_clr_pulse: assert property (p_clr_pulse) else $error("clear held");
    property p_clr_effect; clear_fault |-> ##[1:4] !status_bits[ST_FAULT]; endproperty
    a_clr_effect: assert property (p_clr_effect) else $error("fault kept");
    // The fault flag outlives the fault phase when the input goes away, so only one direction
    property p_fault_bit;
        ph == BCC_FAULT && !status_bits[ST_THERM] |-> status_bits[ST_FAULT];
    endproperty
    a_fault_bit: assert property (p_fault_bit) else $error("fault bit off");
    property p_fault_entry;
        ph == BCC_FAULT && $past(ph) != BCC_FAULT |-> $past(ph) inside {BCC_PRECOND, BCC_CC, BCC_CV};
    endproperty
    a_fault_entry: assert property (p_fault_entry) else $error("bad fault entry");
    property p_precond_exit; $past(ph) == BCC_PRECOND |-> ph != BCC_CV && ph != BCC_DONE; endproperty
    a_precond_exit: assert property (p_precond_exit) else $error("phase skipped");
    property p_cv_entry; ph == BCC_CV && $past(ph) != BCC_CV |-> $past(ph) == BCC_CC; endproperty
    a_cv_entry: assert property (p_cv_entry) else $error("bad cv entry");
    // Phase must hold across a thermal suspend so the timers resume where they stopped
    property p_therm_hold;
        status_bits[ST_THERM] && $past(status_bits[ST_THERM]) |-> $stable(ph);
    endproperty
    a_therm_hold: assert property (p_therm_hold) else $error("phase moved");
    property p_src_none;
        status_bits[4:3] == BCC_SRC_NONE |-> ph inside {BCC_SLEEP, BCC_FAULT, BCC_WAIT};
    endproperty
    a_src_none: assert property (p_src_none) else $error("charging sourceless");
    property p_precond_entry;
        ph == BCC_PRECOND && $past(ph) != BCC_PRECOND |-> $past(ph) != BCC_CC;
    endproperty
    a_precond_entry: assert property (p_precond_entry) else $error("bad precond");
endmodule
`default_nettype wire

// *** testbench/battery_charger_control_bench.sv ***
// Self-checking bench for the charger control device and its host controller
`timescale 1ns/1ps
`default_nettype none
module battery_charger_control_bench;
    import bcc_pkg::*;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rv;
    logic pready, pslverr, er;
    logic ac = 0, usb = 0, ovp = 0, low = 0, rch = 0, cold = 0, hot = 0, term = 0, taper = 0;
    logic repl = 0;
    logic pass_on, detect, usb500, sleep;
    logic [3:0] current;
    bcc_src_t src;
    int fails = 0;
    int comparisons = 0;
    always #5 mclk_i = ~mclk_i;
    bcc_link_if bcc_link_if_i();
    bcc_charger bcc_charger_i(.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
        .link(bcc_link_if_i.device), .ac_valid_i(ac), .usb_valid_i(usb), .ac_ovp_i(ovp),
        .batt_low_i(low), .batt_rch_i(rch), .therm_cold_i(cold), .therm_hot_i(hot),
        .i_below_term_i(term), .i_below_taper_i(taper), .batt_replaced_i(repl),
        .pass_on_o(pass_on), .current_o(current), .detect_cur_o(detect),
        .usb_500_o(usb500), .src_o(src), .sleep_o(sleep));
    bcc_host bcc_host_i(.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .link(bcc_link_if_i.host));
    bcc_link_asserts bcc_link_asserts_i(.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .config_bits(bcc_link_if_i.config_bits), .clear_fault(bcc_link_if_i.clear_fault),
        .status_bits(bcc_link_if_i.status_bits));
    ////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("fails=%0d comparisons=%0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
    endtask
    // Starts one edge late so back-to-back calls never assign psel twice in a step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk_i);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge mclk_i);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk_i);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            fails++;
            stop_test();
        end
        rv = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic phase_is(input bcc_phase_t p);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rv[2:0], p);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic s_reset();
        tick(4);
        chk({pass_on, current, src, usb500}, 8'h00);
        tick(4);
        rst_n_i <= 1'b1;
        apb(1'b0, ADDR_CONFIG, 32'h0);
        chk(rv, {25'h0, CFG_RESET});
        chk(sleep, 1'b1);
        apb(1'b1, 8'h0c, 32'hff);
        chk(er, 1'b1);
        apb(1'b0, 8'h10, 32'h0);
        chk(er, 1'b1);
    endtask
    task automatic s_precond();
        {low, ac} <= 2'b11;
        tick(8);
        chk({pass_on, src}, {1'b1, BCC_SRC_AC});
        chk(current, CUR_TENTH);
        phase_is(BCC_PRECOND);
        low <= 1'b0;
        tick(8);
        chk(current, CUR_FULL);
        phase_is(BCC_CC);
        usb <= 1'b1;
        tick(8);
        chk(src, BCC_SRC_AC);
        ovp <= 1'b1;
        tick(8);
        chk(pass_on, 1'b0);
        {ovp, usb} <= 2'b00;
        tick(8);
        chk(pass_on, 1'b1);
    endtask
    task automatic s_therm();
        for (int k = 0; k < 2; k++) begin
            {hot, cold} <= (k == 0) ? 2'b10 : 2'b01;
            tick(8);
            chk(pass_on, 1'b0);
            apb(1'b0, ADDR_STATUS, 32'h0);
            chk({rv[ST_THERM], rv[2:0]}, {1'b1, BCC_CC});
            {hot, cold} <= 2'b00;
            tick(8);
            chk(pass_on, 1'b1);
            phase_is(BCC_CC);
        end
    endtask
    task automatic s_cfg();
        apb(1'b1, ADDR_CONFIG, 32'h40);
        tick(8);
        chk(pass_on, 1'b0);
        apb(1'b1, ADDR_CONFIG, 32'h0);
        tick(8);
        chk(pass_on, 1'b1);
        taper <= 1'b1;
        tick(8);
        phase_is(BCC_CV);
        term <= 1'b1;
        tick(8);
        phase_is(BCC_DONE);
        chk(pass_on, 1'b0);
        {term, taper, rch} <= 3'b001;
        tick(8);
        phase_is(BCC_CC);
        rch <= 1'b0;
    endtask
    task automatic s_usb();
        {ac, usb} <= 2'b01;
        tick(8);
        chk({pass_on, src, usb500}, {1'b0, BCC_SRC_NONE, 1'b0});
        tick(USB_DELAY_CYC);
        chk({pass_on, src}, {1'b1, BCC_SRC_USB});
        apb(1'b1, ADDR_CONFIG, 32'h01);
        tick(4);
        chk(usb500, 1'b1);
        apb(1'b1, ADDR_CONFIG, 32'h02);
        tick(8);
        chk(pass_on, 1'b0);
        apb(1'b1, ADDR_CMD, 32'h01);
        chk(er, 1'b0);
        usb <= 1'b0;
        tick(8);
        chk({sleep, pass_on}, 2'b10);
        phase_is(BCC_SLEEP);
    endtask
    task automatic s_fault();
        apb(1'b1, ADDR_CONFIG, 32'h0);
        {low, ac} <= 2'b11;
        tick(8);
        phase_is(BCC_PRECOND);
        tick(PRECHG_CYC + 8);
        phase_is(BCC_FAULT);
        chk(rv[ST_FAULT], 1'b1);
        chk({detect, current}, {1'b1, CUR_OFF});
        apb(1'b1, ADDR_CMD, 32'h01);
        tick(8);
        phase_is(BCC_PRECOND);
        chk(rv[ST_FAULT], 1'b0);
        tick(PRECHG_CYC + 8);
        phase_is(BCC_FAULT);
        repl <= 1'b1;
        tick(8);
        repl <= 1'b0;
        phase_is(BCC_PRECOND);
        chk(detect, 1'b0);
        low <= 1'b0;
        tick(8);
        phase_is(BCC_CC);
        ac <= 1'b0;
        tick(8);
    endtask
    initial begin
        s_reset();
        s_precond();
        s_therm();
        s_cfg();
        s_usb();
        s_fault();
        stop_test();
    end
endmodule
`default_nettype wire
